/* File: design/rim_map.svh */
/*
  Constants for the radio interrupt line mapping block.
  Assumes a 50 MHz system clock; included by bare name.
*/
`ifndef RIM_MAP_SVH
`define RIM_MAP_SVH
// line numbers, which are also inherent priorities
`define RIM_NUM_LINES 21
`define RIM_LINE_WAKE 0
`define RIM_LINE_RADIO 1
`define RIM_LINE_SER1 2
`define RIM_LINE_SER2 3
`define RIM_LINE_EXT 4
// sources merged onto the combined radio line
`define RIM_NUM_SRC 9
`define RIM_SRC_FINE 0
`define RIM_SRC_GROSS 1
`define RIM_SRC_TICK 2
`define RIM_SRC_SLEEP 3
`define RIM_SRC_ERR 4
`define RIM_SRC_RX 5
`define RIM_SRC_EVT 6
`define RIM_SRC_CRYPT 7
`define RIM_SRC_SW 8
// timing
`define RIM_CLK_PERIOD_NS 20
`define RIM_BASE_PERIOD_NS 625000
`define RIM_BASE_CYCLES ((`RIM_BASE_PERIOD_NS + `RIM_CLK_PERIOD_NS - 1) / `RIM_CLK_PERIOD_NS)
`define RIM_GROSS_DIV 16
`define RIM_GROSS_PRE_W 4
`define RIM_TIMER_W 16
`endif

/* File: design/rim_pkg.sv */
/*
  Types for the radio interrupt line mapping block.
  Assumes rim_map.svh is on the include path.
*/
`include "rim_map.svh"
package rim_pkg;
  // one-cycle event pulses from the radio baseband
  typedef struct packed {
    logic lowpower_wake;
    logic error;
    logic rx;
    logic event_end;
    logic crypto_done;
  } rim_radio_evt_t;
  typedef logic [`RIM_NUM_SRC-1:0] rim_src_vec_t;
  typedef logic [`RIM_NUM_LINES-1:0] rim_line_vec_t;
endpackage

/* File: design/rim_irq_map.sv */
/*
  Radio interrupt line mapping: sticky radio sources, base tick,
  fine and gross target timers, line vector and wake request.
  Assumes every input except arst_n is synchronous to clk and that event
  inputs are one-cycle pulses.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rim_map.svh"
module rim_irq_map
  import rim_pkg::*;
#(
  parameter int BASE_TICK_CYCLES = `RIM_BASE_CYCLES,
  parameter int TIMER_W = `RIM_TIMER_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire rim_radio_evt_t radio_evt,
  input wire logic sw_request,
  input wire logic radio_active,
  input wire logic fine_load,
  input wire logic [TIMER_W-1:0] fine_value,
  input wire logic gross_load,
  input wire logic [TIMER_W-1:0] gross_value,
  input wire rim_src_vec_t src_clear,
  input wire logic wake_clear,
  input wire logic serial1_irq,
  input wire logic serial2_irq,
  input wire logic [`RIM_NUM_LINES-`RIM_LINE_EXT-1:0] ext_irq,
  input wire logic core_sleeping,
  output var rim_line_vec_t irq_line_q,
  output var rim_src_vec_t pend_q,
  output var logic base_tick_q,
  output var logic wake_req_q
);

  localparam int CNT_W = $clog2(BASE_TICK_CYCLES + 1);
  localparam logic [CNT_W-1:0] TICK_LAST =
    CNT_W'(BASE_TICK_CYCLES - 1);
  localparam logic [`RIM_GROSS_PRE_W-1:0] PRE_LAST =
    `RIM_GROSS_PRE_W'(`RIM_GROSS_DIV - 1);

  // refuse settings the counters cannot serve
  if (BASE_TICK_CYCLES < 2 || TIMER_W < 2) begin : g_chk
    $error("rim_irq_map: unsupported parameter values");
  end

  //**********************************************************
  // base time tick
  //**********************************************************
  logic [CNT_W-1:0] tick_cnt_q;
  logic act_prev_q;
  logic sleep_end_q;

  // counter held at zero in sleep so the first tick after wake
  // lands one full period later, never a short one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_q <= '0;
      base_tick_q <= 1'b0;
    end else if (!radio_active) begin
      tick_cnt_q <= '0;
      base_tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= '0;
      base_tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + CNT_W'(1);
      base_tick_q <= 1'b0;
    end
  end

  // leaving sleep is the rising edge of radio_active
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      act_prev_q <= 1'b0;
      sleep_end_q <= 1'b0;
    end else begin
      act_prev_q <= radio_active;
      sleep_end_q <= radio_active & ~act_prev_q;
    end
  end

  //**********************************************************
  // fine target timer
  //**********************************************************
  logic [TIMER_W-1:0] fine_cnt_q;
  logic fine_run_q;
  logic fine_exp_q;

  // counts base ticks; a load of zero expires on the next tick
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fine_cnt_q <= '0;
      fine_run_q <= 1'b0;
      fine_exp_q <= 1'b0;
    end else if (fine_load) begin
      fine_cnt_q <= fine_value;
      fine_run_q <= 1'b1;
      fine_exp_q <= 1'b0;
    end else if (fine_run_q && base_tick_q) begin
      if (fine_cnt_q <= TIMER_W'(1)) begin
        fine_cnt_q <= '0;
        fine_run_q <= 1'b0;
        fine_exp_q <= 1'b1;
      end else begin
        fine_cnt_q <= fine_cnt_q - TIMER_W'(1);
        fine_exp_q <= 1'b0;
      end
    end else begin
      fine_exp_q <= 1'b0;
    end
  end

  //**********************************************************
  // gross target timer
  //**********************************************************
  logic [TIMER_W-1:0] gross_cnt_q;
  logic [`RIM_GROSS_PRE_W-1:0] gross_pre_q;
  logic gross_run_q;
  logic gross_exp_q;
  logic gross_step;

  // one gross step per sixteen base ticks
  assign gross_step = base_tick_q && (gross_pre_q == PRE_LAST);

  // prescaler restarts on load so the first step is whole
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gross_pre_q <= '0;
    end else if (gross_load) begin
      gross_pre_q <= '0;
    end else if (gross_run_q && base_tick_q) begin
      gross_pre_q <= gross_pre_q + `RIM_GROSS_PRE_W'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gross_cnt_q <= '0;
      gross_run_q <= 1'b0;
      gross_exp_q <= 1'b0;
    end else if (gross_load) begin
      gross_cnt_q <= gross_value;
      gross_run_q <= 1'b1;
      gross_exp_q <= 1'b0;
    end else if (gross_run_q && gross_step) begin
      if (gross_cnt_q <= TIMER_W'(1)) begin
        gross_cnt_q <= '0;
        gross_run_q <= 1'b0;
        gross_exp_q <= 1'b1;
      end else begin
        gross_cnt_q <= gross_cnt_q - TIMER_W'(1);
        gross_exp_q <= 1'b0;
      end
    end else begin
      gross_exp_q <= 1'b0;
    end
  end

  //**********************************************************
  // sticky radio sources
  //**********************************************************
  rim_src_vec_t src_set;
  logic wake_pend_q;

  // gather the nine event pulses into one vector
  always_comb begin
    src_set = '0;
    src_set[`RIM_SRC_FINE] = fine_exp_q;
    src_set[`RIM_SRC_GROSS] = gross_exp_q;
    src_set[`RIM_SRC_TICK] = base_tick_q;
    src_set[`RIM_SRC_SLEEP] = sleep_end_q;
    src_set[`RIM_SRC_ERR] = radio_evt.error;
    src_set[`RIM_SRC_RX] = radio_evt.rx;
    src_set[`RIM_SRC_EVT] = radio_evt.event_end;
    src_set[`RIM_SRC_CRYPT] = radio_evt.crypto_done;
    src_set[`RIM_SRC_SW] = sw_request;
  end

  // a set in the clearing cycle wins, so no event is lost
  for (genvar i = 0; i < `RIM_NUM_SRC; i++) begin : g_pend
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        pend_q[i] <= 1'b0;
      end else begin
        pend_q[i] <= src_set[i] | (pend_q[i] & ~src_clear[i]);
      end
    end
  end

  // extended sleep wake is held until acknowledged
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_pend_q <= 1'b0;
    end else begin
      wake_pend_q <= radio_evt.lowpower_wake
        | (wake_pend_q & ~wake_clear);
    end
  end

  //**********************************************************
  // line vector and wake request
  //**********************************************************
  rim_line_vec_t line_d;

  // lines 2 and up are levels from their owners, passed through
  always_comb begin
    line_d = '0;
    line_d[`RIM_LINE_WAKE] = wake_pend_q;
    line_d[`RIM_LINE_RADIO] = |pend_q;
    line_d[`RIM_LINE_SER1] = serial1_irq;
    line_d[`RIM_LINE_SER2] = serial2_irq;
    line_d[`RIM_NUM_LINES-1:`RIM_LINE_EXT] = ext_irq;
  end

  // priority is left to the core controller, which ranks by number
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_line_q <= '0;
    end else begin
      irq_line_q <= line_d;
    end
  end

  // raised from the same vector so the core never misses a line
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_req_q <= 1'b0;
    end else begin
      wake_req_q <= core_sleeping & (|line_d);
    end
  end

  //**********************************************************
  // assertions
  //**********************************************************
  logic pend_any;
  assign pend_any = |pend_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_wake_line;
    radio_evt.lowpower_wake |=> ##1 irq_line_q[`RIM_LINE_WAKE];
  endproperty
  a_wake_line: assert property (p_wake_line)
    else $error("wake event did not raise line 0");
  property p_radio_or;
    ##1 irq_line_q[`RIM_LINE_RADIO] == $past(pend_any);
  endproperty
  a_radio_or: assert property (p_radio_or)
    else $error("line 1 differs from OR of pending sources");
  property p_ser2_pass;
    ##1 irq_line_q[`RIM_LINE_SER2] == $past(serial2_irq);
  endproperty
  a_ser2_pass: assert property (p_ser2_pass)
    else $error("line 3 does not follow the serial input");
  property p_tick_sleep;
    !radio_active |=> !base_tick_q;
  endproperty
  a_tick_sleep: assert property (p_tick_sleep)
    else $error("base tick while radio asleep");
  property p_tick_gap;
    base_tick_q |=> !base_tick_q [*1];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("base ticks back to back");
  property p_fine_fire;
    fine_exp_q |-> $past(base_tick_q) ##1 pend_q[`RIM_SRC_FINE];
  endproperty
  a_fine_fire: assert property (p_fine_fire)
    else $error("fine expiry off tick or not pended");
  property p_gross_fire;
    gross_exp_q |-> $past(gross_step) ##1 pend_q[`RIM_SRC_GROSS];
  endproperty
  a_gross_fire: assert property (p_gross_fire)
    else $error("gross expiry off step or not pended");
  property p_sleep_end;
    radio_active && !act_prev_q |=> sleep_end_q ##1
      pend_q[`RIM_SRC_SLEEP];
  endproperty
  a_sleep_end: assert property (p_sleep_end)
    else $error("sleep exit not pended");
  property p_err_set;
    radio_evt.error |=> pend_q[`RIM_SRC_ERR];
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("error event not pended");
  property p_rx_wins;
    radio_evt.rx && src_clear[`RIM_SRC_RX] |=> pend_q[`RIM_SRC_RX];
  endproperty
  a_rx_wins: assert property (p_rx_wins)
    else $error("reception lost against clear");
  property p_evt_set;
    radio_evt.event_end |=> ##1 irq_line_q[`RIM_LINE_RADIO];
  endproperty
  a_evt_set: assert property (p_evt_set)
    else $error("event end did not raise line 1");
  property p_crypt_set;
    radio_evt.crypto_done |=> pend_q[`RIM_SRC_CRYPT];
  endproperty
  a_crypt_set: assert property (p_crypt_set)
    else $error("crypto completion not pended");
  property p_sw_set;
    sw_request |=> pend_q[`RIM_SRC_SW];
  endproperty
  a_sw_set: assert property (p_sw_set)
    else $error("software request not pended");
  // the core may be woken meanwhile by an earlier wake request, so follow its sleep level
  property p_wake_unit;
    core_sleeping && sw_request |=> ##1 wake_req_q == $past(core_sleeping);
  endproperty
  a_wake_unit: assert property (p_wake_unit)
    else $error("sleeping core not woken");

  c_fine: cover property (fine_exp_q);
  c_gross: cover property (gross_exp_q);
  c_wake: cover property (wake_req_q && irq_line_q[`RIM_LINE_WAKE]);
  c_clear: cover property (pend_q[`RIM_SRC_RX] ##1 !pend_q[`RIM_SRC_RX]);

endmodule
`default_nettype wire

/* File: verif/rim_core_model.sv */
/*
  Core-side interrupt controller model: sleeps on command, wakes
  on the wake request, takes the highest-priority pending line.
  Assumes registered level lines from rim_irq_map.
*/
`timescale 1ns/10ps
`default_nettype none
module rim_core_model
  import rim_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire rim_line_vec_t irq_line,
  input wire logic wake_req,
  input wire logic sleep_cmd,
  output var logic core_sleeping,
  output var logic [4:0] taken_line
);
  // ********************
  // sleep and response
  // ********************
  int wait_q;
  // stays asleep until woken, never wakes on its own
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      core_sleeping <= 1'b0;
    end else if (sleep_cmd) begin
      core_sleeping <= 1'b1;
    end else if (wake_req) begin
      core_sleeping <= 1'b0;
    end
  end
  // answers no sooner than 16 cycles; lowest number wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q <= 0;
      taken_line <= 5'h1f;
    end else if (core_sleeping || irq_line == '0) begin
      wait_q <= 0;
    end else if (wait_q < 15) begin
      wait_q <= wait_q + 1;
    end else begin
      wait_q <= 0;
      for (int i = 20; i >= 0; i--) begin
        if (irq_line[i]) taken_line <= 5'(i);
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
/*
  Self-checking bench for rim_irq_map beside the core model.
  Assumes rim_pkg and rim_map.svh compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rim_map.svh"
module tb
  import rim_pkg::*;
;
  // ********************
  // signals and parts
  // ********************
  localparam int TICK = 8; // short base period keeps the run brief
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  rim_radio_evt_t radio_evt = '0;
  logic sw_request = 1'b0, radio_active = 1'b0, sleep_cmd = 1'b0;
  logic fine_load = 1'b0, gross_load = 1'b0, wake_clear = 1'b0;
  logic [15:0] fine_value = '0, gross_value = '0;
  rim_src_vec_t src_clear = '0;
  logic serial1_irq = 1'b0, serial2_irq = 1'b0, seen = 1'b0;
  logic [16:0] ext_irq = '0;
  logic core_sleeping, base_tick_q, wake_req_q;
  rim_line_vec_t irq_line_q;
  rim_src_vec_t pend_q;
  logic [4:0] taken_line;
  logic [31:0] obs;
  int fail_count = 0, comparisons = 0, seed = 32'h511e, n, s;
  assign obs = {base_tick_q, wake_req_q, irq_line_q, pend_q};
  always #10 clk = ~clk;
  rim_irq_map #(.BASE_TICK_CYCLES(TICK)) u_rim_irq_map (.clk(clk),
    .arst_n(arst_n), .radio_evt(radio_evt), .sw_request(sw_request),
    .radio_active(radio_active), .fine_load(fine_load),
    .fine_value(fine_value), .gross_load(gross_load),
    .gross_value(gross_value), .src_clear(src_clear),
    .wake_clear(wake_clear), .serial1_irq(serial1_irq),
    .serial2_irq(serial2_irq), .ext_irq(ext_irq),
    .core_sleeping(core_sleeping), .irq_line_q(irq_line_q),
    .pend_q(pend_q), .base_tick_q(base_tick_q),
    .wake_req_q(wake_req_q));
  rim_core_model u_rim_core_model (.clk(clk), .arst_n(arst_n),
    .irq_line(irq_line_q), .wake_req(wake_req_q),
    .sleep_cmd(sleep_cmd), .core_sleeping(core_sleeping),
    .taken_line(taken_line));
  // ********************
  // tasks
  // ********************
  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp);
    comparisons++;
    if (seen_v !== exp) begin
      $display("mismatch at %0t: seen %h expected %h", $time, seen_v, exp);
      fail_count++;
    end
  endtask
  task automatic close_out;
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask
  // bounded wait for a probe bit; n counts the falling edges
  task automatic wait_hi(input int idx, input int lim);
    n = 0;
    while (obs[idx] !== 1'b1) begin
      if (n >= lim) begin
        fail_count++;
        close_out();
      end
      step(1);
      n++;
    end
  endtask
  function automatic rim_radio_evt_t evt_of(input int src);
    rim_radio_evt_t e;
    e = '0;
    e.error = (src == `RIM_SRC_ERR);
    e.rx = (src == `RIM_SRC_RX);
    e.event_end = (src == `RIM_SRC_EVT);
    e.crypto_done = (src == `RIM_SRC_CRYPT);
    e.lowpower_wake = (src < 0);
    return e;
  endfunction
  // one-cycle source pulse; -1 stands for the low-power wake
  task automatic pulse(input int src);
    radio_evt = evt_of(src);
    sw_request = (src == `RIM_SRC_SW);
    step(1);
    radio_evt = '0;
    sw_request = 1'b0;
  endtask
  task automatic clear(input rim_src_vec_t m);
    src_clear = m;
    step(1);
    src_clear = '0;
    step(3);
  endtask
  task automatic next_tick;
    step(1);
    wait_hi(31, TICK + 2);
  endtask
  // ********************
  // sequence
  // ********************
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end
  initial begin
    step(10);
    arst_n = 1'b1;
    step(1);
    check(obs, '0);
    for (s = `RIM_SRC_ERR; s <= `RIM_SRC_SW; s++) begin
      pulse(s);
      wait_hi(s, 3);
      step(1);
      check(pend_q, 9'h1 << s);
      check(irq_line_q[1:0], 2'b10);
      clear(pend_q);
      check({pend_q, irq_line_q[1]}, '0);
    end
    // line 1 must hold while any source is left pending
    pulse(`RIM_SRC_RX);
    step(1);
    pulse(`RIM_SRC_EVT);
    step(3);
    clear(9'h020);
    check({pend_q, irq_line_q[1]}, {9'h040, 1'b1});
    clear(9'h040);
    check(irq_line_q[1], 1'b0);
    pulse(-1);
    wait_hi(9, 4);
    step(20);
    check({irq_line_q[1:0], taken_line, wake_req_q}, 8'h40);
    sleep_cmd = 1'b1;
    step(1);
    sleep_cmd = 1'b0;
    wait_hi(30, 3);
    step(2);
    check(core_sleeping, 1'b0);
    wake_clear = 1'b1;
    step(1);
    wake_clear = 1'b0;
    step(3);
    check(irq_line_q[0], 1'b0);
    // a software request alone must wake a sleeping core
    sleep_cmd = 1'b1;
    step(1);
    sleep_cmd = 1'b0;
    step(3);
    check({core_sleeping, wake_req_q}, 2'b10);
    pulse(`RIM_SRC_SW);
    wait_hi(30, 3);
    step(2);
    check({core_sleeping, pend_q}, 10'h100);
    clear(9'h100);
    // all-ones corner first, then random levels
    {ext_irq, serial2_irq, serial1_irq} = 19'h7ffff;
    repeat (40) begin
      step(1);
      check(irq_line_q[20:2], {ext_irq, serial2_irq, serial1_irq});
      {ext_irq, serial2_irq, serial1_irq} = 19'($random(seed));
    end
    {ext_irq, serial2_irq, serial1_irq} = '0;
    radio_active = 1'b1;
    wait_hi(3, 4);
    wait_hi(31, TICK + 3);
    next_tick;
    check(n, TICK - 1);
    check(pend_q[2], 1'b1);
    clear(9'h1ff);
    next_tick;
    fine_value = 16'h0002;
    fine_load = 1'b1;
    step(1);
    fine_load = 1'b0;
    next_tick;
    step(3);
    check(pend_q[0], 1'b0);
    next_tick;
    wait_hi(0, 4);
    next_tick;
    gross_value = 16'h0001;
    gross_load = 1'b1;
    step(1);
    gross_load = 1'b0;
    repeat (15) next_tick;
    step(3);
    check(pend_q[1], 1'b0);
    next_tick;
    wait_hi(1, 4);
    radio_active = 1'b0;
    step(2);
    repeat (3 * TICK) begin
      step(1);
      seen = seen | base_tick_q;
    end
    check(seen, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
